// ===== hdl/bps_bridge_protection_supervisor.v
// protection, fault latching and output decision for an h-bridge driver
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "bps_defines.vh"
`default_nettype none

module bps_bridge_protection_supervisor (
	// clock and reset
	input  wire        clk_sys,
	input  wire        reset,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// control pins, each with an open-pin detect
	input  wire        enable_pin,
	input  wire        enable_pin_open,
	input  wire        disable_pin,
	input  wire        disable_pin_open,
	input  wire        direction_input_a,
	input  wire        direction_input_a_open,
	input  wire        direction_input_b,
	input  wire        direction_input_b_open,
	// comparator indications
	input  wire        supply_low_ind,
	input  wire        supply_recovered_ind,
	input  wire        supply_high_ind,
	input  wire        overtemp_ind,
	input  wire        thermal_warn_ind,
	input  wire        short_a_ind,
	input  wire        short_b_ind,
	// bridge and status
	output reg         bridge_output_a,
	output reg         bridge_output_a_oe,
	output reg         bridge_output_b,
	output reg         bridge_output_b_oe,
	output reg         fault_status_out_n
);

	// ****************************************
	// input synchronisers
	// ****************************************
	wire [14:0] pins_raw;
	reg  [14:0] meta_q;
	reg  [14:0] sync_q;
	reg  [14:0] prev_q;

	assign pins_raw = {short_b_ind, short_a_ind, thermal_warn_ind, overtemp_ind,
		supply_high_ind, supply_recovered_ind, supply_low_ind,
		direction_input_b_open, direction_input_b, direction_input_a_open,
		direction_input_a, disable_pin_open, disable_pin, enable_pin_open, enable_pin};

	always @(posedge clk_sys) begin
		if (reset) begin
			meta_q <= 15'h0000;
			sync_q <= 15'h0000;
			prev_q <= 15'h0000;
		end else begin
			meta_q <= pins_raw;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	wire en_s      = sync_q[0];
	wire en_open_s = sync_q[1];
	wire hold_s    = sync_q[2];
	wire hold_opn  = sync_q[3];
	wire dir_a_s   = sync_q[4];
	wire dir_a_opn = sync_q[5];
	wire dir_b_s   = sync_q[6];
	wire dir_b_opn = sync_q[7];
	wire ind_low   = sync_q[8];
	wire ind_recov = sync_q[9];
	wire ind_high  = sync_q[10];
	wire ind_hot   = sync_q[11];
	wire ind_warm  = sync_q[12];
	wire ind_sca   = sync_q[13];
	wire ind_scb   = sync_q[14];

	// any change of the enable or disable pin releases latched faults
	wire pin_clear = (sync_q[1:0] != prev_q[1:0]) || (sync_q[3:2] != prev_q[3:2]);

	// ****************************************
	// filters
	// ****************************************
	// the genvar is passed whole, so no index bits are dropped
	function [10:0] filt_limit;
		input integer idx;
		begin
			case (idx)
				0: filt_limit = `BPS_UV_FILT_CYC;
				1: filt_limit = `BPS_UV_FILT_CYC;
				2: filt_limit = `BPS_HI_FILT_CYC;
				default: filt_limit = `BPS_HOT_FILT_CYC;
			endcase
		end
	endfunction

	wire [3:0] filt_in = {ind_hot, ind_high, ind_recov, ind_low};
	wire [3:0] filt_hit;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_filt
			reg [10:0] cnt_q;
			// counter saturates at its limit; any drop of the level restarts it
			always @(posedge clk_sys) begin
				if (reset || !filt_in[gi]) begin
					cnt_q <= 11'h000;
				end else if (cnt_q != filt_limit(gi)) begin
					cnt_q <= cnt_q + 11'h001;
				end
			end
			assign filt_hit[gi] = (cnt_q == filt_limit(gi));
		end
	endgenerate

	// ****************************************
	// registers and apb
	// ****************************************
	reg  [4:0] ctrl_q;
	reg  [5:0] mask_q;
	reg        resp_off_q;
	reg        uv_lock_q;
	reg        hi_active_q;
	reg        flag_hot_q;
	reg        flag_sca_q;
	reg        flag_scb_q;
	reg        flag_hi_q;
	reg        flag_uv_q;

	function [3:0] addr_dec;
		input [11:0] a;
		begin
			addr_dec = {a == `BPS_ADDR_OUTS, a == `BPS_ADDR_STATUS,
				a == `BPS_ADDR_MASK, a == `BPS_ADDR_CTRL};
		end
	endfunction

	wire       acc    = psel & penable & ~pready;
	wire [3:0] sel    = addr_dec(paddr);
	wire       wr_acc = acc & pwrite;
	wire [5:0] status = {flag_uv_q, flag_hi_q, flag_scb_q, flag_sca_q, ind_warm, flag_hot_q};
	wire [5:0] clr    = (wr_acc && sel[2]) ? pwdata[5:0] : 6'h00;

	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h0000_0000;
		case (1'b1)
			sel[0]: rd_mux[4:0] = ctrl_q;
			sel[1]: rd_mux = {19'h00000, resp_off_q, 6'h00, mask_q};
			sel[2]: rd_mux[5:0] = status;
			sel[3]: rd_mux[5:0] = {bridge_output_b_oe, bridge_output_a_oe,
				bridge_output_b, bridge_output_a, hi_active_q, uv_lock_q};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// one wait state: pready rises on the second access cycle
	always @(posedge clk_sys) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			ctrl_q  <= `BPS_CTRL_RESET;
			mask_q  <= `BPS_MASK_RESET;
			resp_off_q <= 1'b0;
		end else begin
			pready  <= acc;
			pslverr <= acc & ~(|sel);
			if (acc && !pwrite)
				prdata <= rd_mux;
			if (wr_acc && sel[0])
				ctrl_q <= pwdata[4:0];
			if (wr_acc && sel[1]) begin
				mask_q <= pwdata[5:0];
				resp_off_q <= pwdata[`BPS_MASK_RESP_OFF];
			end
		end
	end

	// ****************************************
	// fault state
	// ****************************************
	// a set in the same cycle as a clear always wins
	always @(posedge clk_sys) begin
		if (reset) begin
			uv_lock_q   <= 1'b1;
			hi_active_q <= 1'b0;
			flag_hot_q  <= 1'b0;
			flag_sca_q  <= 1'b0;
			flag_scb_q  <= 1'b0;
			flag_hi_q   <= 1'b0;
			flag_uv_q   <= 1'b0;
		end else begin
			if (filt_hit[0])
				uv_lock_q <= 1'b1;
			else if (filt_hit[1])
				uv_lock_q <= 1'b0;
			hi_active_q <= filt_hit[2];
			flag_hi_q  <= filt_hit[2] | (flag_hi_q & ~clr[`BPS_ST_HIGH] & ~pin_clear);
			flag_uv_q  <= filt_hit[0] | (flag_uv_q & ~clr[`BPS_ST_UV] & ~pin_clear);
			flag_hot_q <= filt_hit[3] | (flag_hot_q & ~clr[`BPS_ST_HOT] & ~pin_clear);
			flag_sca_q <= ind_sca | (flag_sca_q & ~clr[`BPS_ST_SCA] & ~pin_clear);
			flag_scb_q <= ind_scb | (flag_scb_q & ~clr[`BPS_ST_SCB] & ~pin_clear);
		end
	end

	// ****************************************
	// output decision
	// ****************************************
	wire awake    = en_s & ~en_open_s;
	wire hold_act = hold_s | hold_opn;
	wire permit   = ctrl_q[`BPS_CTRL_PERMIT];
	wire full     = ctrl_q[`BPS_CTRL_MODE];
	wire use_vin  = ctrl_q[`BPS_CTRL_SRC];
	wire in_a     = use_vin ? ctrl_q[`BPS_CTRL_VIN_A] : (dir_a_s & ~dir_a_opn);
	wire in_b     = use_vin ? ctrl_q[`BPS_CTRL_VIN_B] : (dir_b_s & ~dir_b_opn);
	wire a_float  = ~use_vin & dir_a_opn;
	wire any_trip = flag_hot_q | flag_sca_q | flag_scb_q;

	reg drv_a;
	reg drv_b;
	reg oe_a;
	reg oe_b;
	reg fs_n;

	always @*begin
		drv_a = 1'b0;
		drv_b = 1'b0;
		oe_a  = 1'b0;
		oe_b  = 1'b0;
		if (awake && !hold_act && permit && !uv_lock_q) begin
			if (full) begin
				if (any_trip) begin
					oe_a = 1'b0;
					oe_b = 1'b0;
				end else if (hi_active_q && !resp_off_q) begin
					drv_a = 1'b1;
					drv_b = 1'b1;
					oe_a  = 1'b1;
					oe_b  = 1'b1;
				end else begin
					oe_a = 1'b1;
					oe_b = 1'b1;
					if (a_float) begin
						drv_a = ~in_b;
						drv_b = 1'b1;
					end else begin
						drv_a = ~in_b | in_a;
						drv_b = ~in_b | ~in_a;
					end
				end
			end else begin
				// overvoltage has no effect here, only its flag
				drv_a = in_a;
				drv_b = in_b;
				oe_a  = ~flag_hot_q & ~flag_sca_q;
				oe_b  = ~flag_hot_q & ~flag_scb_q;
			end
		end
		if (!awake)
			fs_n = 1'b1;
		else if (hold_act)
			fs_n = 1'b0;
		else
			fs_n = ~(|(status & mask_q));
	end

	// the response-off bit only stops the output action; the flag still reaches fs via the mask
	always @(posedge clk_sys) begin
		if (reset) begin
			bridge_output_a    <= 1'b0;
			bridge_output_b    <= 1'b0;
			bridge_output_a_oe <= 1'b0;
			bridge_output_b_oe <= 1'b0;
			fault_status_out_n <= 1'b1;
		end else begin
			bridge_output_a    <= drv_a;
			bridge_output_b    <= drv_b;
			bridge_output_a_oe <= oe_a;
			bridge_output_b_oe <= oe_b;
			fault_status_out_n <= fs_n;
		end
	end

endmodule

`default_nettype wire

// ===== hdl/bps_defines.vh
// constants for the bridge protection supervisor
`ifndef BPS_DEFINES_VH
`define BPS_DEFINES_VH

// ****************************************
// register byte addresses
// ****************************************
`define BPS_ADDR_CTRL   12'h000
`define BPS_ADDR_MASK   12'h004
`define BPS_ADDR_STATUS 12'h008
`define BPS_ADDR_OUTS   12'h00c

// ****************************************
// control register fields
// ****************************************
`define BPS_CTRL_VIN_A  0
`define BPS_CTRL_VIN_B  1
`define BPS_CTRL_SRC    2
`define BPS_CTRL_MODE   3
`define BPS_CTRL_PERMIT 4
`define BPS_CTRL_RESET  5'h18

// ****************************************
// status and mask fields (same order)
// ****************************************
`define BPS_ST_HOT      0
`define BPS_ST_WARN     1
`define BPS_ST_SCA      2
`define BPS_ST_SCB      3
`define BPS_ST_HIGH     4
`define BPS_ST_UV       5
`define BPS_MASK_RESP_OFF 12
`define BPS_MASK_RESET  6'h3d

// ****************************************
// filter times
// ****************************************
`define BPS_CLK_PERIOD_NS 10
`define BPS_UV_FILT_NS    10000
`define BPS_HI_FILT_NS    3000
`define BPS_HOT_FILT_NS   11000
// cycle counts at the clock period above, sized to the 11-bit filter counters
`define BPS_UV_FILT_CYC   11'h3e8
`define BPS_HI_FILT_CYC   11'h12c
`define BPS_HOT_FILT_CYC  11'h44c

`endif

// ===== verification/bps_bridge_protection_supervisor_test.sv
// self-checking bench for the bridge protection supervisor
`timescale 1ns/1ns
`include "bps_defines.vh"
`default_nettype none
module bps_bridge_protection_supervisor_test;
	// ********
	// signals
	// ********
	logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, e;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic pready, pslverr, en, dpin, qa, qb, ae, be, fs;
	logic w_en = 0, w_off = 0, clr = 0, ia = 0, ib = 0, fa = 0, fb = 0;
	logic rec = 1, hi = 0, hot = 0, warm = 0, sa = 0, lo = 0, eopen = 0, dopen = 0;
	logic [4:0] c;
	int num_errors = 0, num_checks = 0;
	always #5 clk_sys = ~clk_sys;
	bps_host host (.clk_sys, .want_en(w_en), .want_off(w_off), .clr_req(clr),
		.enable_pin(en), .disable_pin(dpin));
	bps_bridge_protection_supervisor dut (.clk_sys, .reset, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .enable_pin(en), .enable_pin_open(eopen),
		.disable_pin(dpin), .disable_pin_open(dopen), .direction_input_a(ia),
		.direction_input_a_open(fa), .direction_input_b(ib), .direction_input_b_open(fb),
		.supply_low_ind(lo), .supply_recovered_ind(rec), .supply_high_ind(hi),
		.overtemp_ind(hot), .thermal_warn_ind(warm), .short_a_ind(sa), .short_b_ind(1'b0),
		.bridge_output_a(qa), .bridge_output_a_oe(ae), .bridge_output_b(qb),
		.bridge_output_b_oe(be), .fault_status_out_n(fs));
	// ********
	// tasks
	// ********
	task results;
		$display("errors %0d checks %0d", num_errors, num_checks);
		if (num_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		if (pready !== 1'b1) begin
			num_errors++;
			results();
		end
	endtask
	// status, both enables, both outputs seen only when driven
	task look(input logic [4:0] x);
		repeat (6) @(posedge clk_sys);
		chk({fs, ae, be, qa & ae, qb & be}, x);
	endtask
	function automatic logic [4:0] exp5(logic [4:0] k);
		logic x, y;
		x = k[2] ? k[0] : ia & !fa;
		y = k[2] ? k[1] : ib & !fb;
		if (!k[4])
			return 5'h10;
		if (!k[3])
			return {3'h7, x, y};
		if (!k[2] && fa)
			return {3'h7, !y, 1'b1};
		return {3'h7, y ? {x, !x} : 2'h3};
	endfunction
	// ********
	// sequence
	// ********
	initial begin
		r = $urandom(63437);
		repeat (8) @(posedge clk_sys);
		reset <= 0;
		repeat (1010) @(posedge clk_sys);
		w_en <= 1;
		apb(1, `BPS_ADDR_STATUS, 32'h3f);
		apb(0, 12'h010, 0);
		chk(e, 1);
		chk(r, 0);
		repeat (40) begin
			c = $urandom;
			{ia, ib, fa, fb, warm} <= $urandom;
			apb(1, `BPS_ADDR_CTRL, {27'h7ff, c});
			apb(0, `BPS_ADDR_CTRL, 0);
			chk(r, c);
			look(exp5(c));
			apb(0, `BPS_ADDR_STATUS, 0);
			chk(r[1], warm);
		end
		{ia, ib, fa, fb, warm} <= 5'h08;
		for (int i = 0; i < 3; i++) begin
			apb(1, `BPS_ADDR_CTRL, i == 1 ? 32'h10 : 32'h18);
			apb(1, `BPS_ADDR_MASK, i == 2 ? 32'h103d : 32'h3d);
			hi <= 1;
			repeat (290) @(posedge clk_sys);
			look(5'h1d);
			repeat (10) @(posedge clk_sys);
			look(i == 0 ? 5'h0f : 5'h0d);
			hi <= 0;
			look(5'h0d);
			apb(0, `BPS_ADDR_STATUS, 0);
			chk(r[4], 1);
			apb(1, `BPS_ADDR_STATUS, 32'h10);
			look(5'h1d);
		end
		apb(1, `BPS_ADDR_CTRL, 32'h18);
		hot <= 1;
		repeat (1094) @(posedge clk_sys);
		look(5'h1d);
		repeat (20) @(posedge clk_sys);
		look(5'h00);
		hot <= 0;
		look(5'h00);
		clr <= 1;
		@(posedge clk_sys);
		clr <= 0;
		repeat (6) @(posedge clk_sys);
		look(5'h1d);
		{ia, ib} <= 2'h3;
		apb(1, `BPS_ADDR_CTRL, 32'h10);
		sa <= 1;
		look(5'h05);
		apb(1, `BPS_ADDR_CTRL, 32'h18);
		look(5'h00);
		sa <= 0;
		apb(1, `BPS_ADDR_STATUS, 32'h04);
		look(5'h1e);
		// supply low must outlast its filter, and recovery must hold for its own
		lo <= 1;
		rec <= 0;
		repeat (990) @(posedge clk_sys);
		look(5'h1e);
		repeat (10) @(posedge clk_sys);
		look(5'h00);
		lo <= 0;
		rec <= 1;
		repeat (990) @(posedge clk_sys);
		look(5'h00);
		repeat (10) @(posedge clk_sys);
		look(5'h0e);
		apb(1, `BPS_ADDR_STATUS, 32'h20);
		look(5'h1e);
		dopen <= 1;
		look(5'h00);
		dopen <= 0;
		look(5'h1e);
		eopen <= 1;
		look(5'h10);
		eopen <= 0;
		look(5'h1e);
		w_off <= 1;
		repeat (4) @(posedge clk_sys);
		look(5'h00);
		w_off <= 0;
		w_en <= 0;
		look(5'h10);
		results();
	end
endmodule
`default_nettype wire

// ===== verification/bps_checker_assertions.sv
// port assertions for the bridge protection supervisor
`timescale 1ns/1ns
`default_nettype none
module bps_checker (
	// clock, reset and apb
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins and outputs
	input wire logic        enable_pin,
	input wire logic        disable_pin,
	input wire logic        supply_recovered_ind,
	input wire logic        overtemp_ind,
	input wire logic        bridge_output_a_oe,
	input wire logic        bridge_output_b_oe,
	input wire logic        fault_status_out_n
);
	// ********
	// helper counters
	// ********
	logic [10:0] hot_q;
	logic [9:0]  up_q;
	wire         off = !bridge_output_a_oe && !bridge_output_b_oe;
	// raw counts run ahead of the synchronised ones, so limits stay safe
	always @(posedge clk_sys) begin
		if (reset || !overtemp_ind)
			hot_q <= 11'h0;
		else if (hot_q != 11'h7ff)
			hot_q <= hot_q + 11'h1;
		if (reset)
			up_q <= 10'h0;
		else if (up_q != 10'h3e8)
			up_q <= supply_recovered_ind ? up_q + 10'h1 : 10'h0;
	end
	// ********
	// properties
	// ********
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence access_s;
		psel && penable && !pready;
	endsequence
	apb_wait_a: assert property (access_s |=> pready) else $error("no ready");
	ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
	err_ready_a: assert property (pslverr |-> pready) else $error("lone error");
	unmapped_err_a: assert property (access_s ##0 paddr > 12'h00c |=> pslverr)
		else $error("no error");
	sleep_off_a: assert property ((!enable_pin)[*5] |-> off && fault_status_out_n)
		else $error("live in sleep");
	disable_off_a: assert property ((enable_pin && disable_pin)[*5] |-> off &&
		!fault_status_out_n) else $error("live when disabled");
	start_lock_a: assert property (up_q != 10'h3e8 |-> off)
		else $error("early start");
	hot_latch_a: assert property (hot_q > 11'h455 |-> off) else $error("hot but live");
endmodule
bind bps_bridge_protection_supervisor bps_checker u_chk (.clk_sys, .reset, .psel, .penable,
	.paddr, .pready, .pslverr, .enable_pin, .disable_pin, .supply_recovered_ind,
	.overtemp_ind, .bridge_output_a_oe, .bridge_output_b_oe, .fault_status_out_n);
`default_nettype wire

// ===== verification/bps_host.sv
// host model driving the enable and disable pins
`timescale 1ns/1ns
`default_nettype none
module bps_host (
	// clock and requests
	input wire logic  clk_sys,
	input wire logic  want_en,
	input wire logic  want_off,
	input wire logic  clr_req,
	// pins
	output var logic  enable_pin,
	output var logic  disable_pin
);
	// ********
	// pin drive
	// ********
	logic [2:0] pulse_q;
	initial begin
		enable_pin = 1'b0;
		disable_pin = 1'b0;
		pulse_q = 3'h0;
	end
	// fault recovery by a short disable pulse, not a power cycle
	always @(posedge clk_sys) begin
		enable_pin <= want_en;
		pulse_q <= clr_req ? 3'h4 : pulse_q - {2'h0, |pulse_q};
		disable_pin <= want_off || pulse_q != 3'h0;
	end
endmodule
`default_nettype wire
